// ---- verilog/prc_pkg.sv ----
package prc_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int FAST_WIN_NS   = 10000;
  localparam int DEF_WIN_NS    = 1000000;
  localparam int HW_PULSE_NS   = 1000;
  localparam int SETTLE_NS     = 200000;
  localparam int POR_HOLD_NS   = 200000;
  localparam int SW_WAIT_NS    = 500000;
  localparam int FAST_WIN_CYC  = FAST_WIN_NS / CLK_PERIOD_NS;
  localparam int DEF_WIN_CYC   = DEF_WIN_NS / CLK_PERIOD_NS;
  localparam int HW_PULSE_CYC  = (HW_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_HOLD_CYC  = (POR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SW_WAIT_CYC   = (SW_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RX_ERR_THRESH = 32;
  localparam int MLT3_THRESH   = 20;
  localparam int SQ_THRESH     = 20;
  // ----------------------------------------------------------------
  // device register map
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_BMC  = 5'h00;
  localparam logic [4:0] REG_SC3  = 5'h0b;
  localparam logic [4:0] REG_SPC  = 5'h11;
  localparam logic [4:0] REG_IRQ1 = 5'h12;
  localparam logic [4:0] REG_IRQ2 = 5'h13;
  localparam logic [4:0] REG_GRC  = 5'h1f;
  localparam int BMC_RESET_BIT   = 15;
  localparam int BMC_PDOWN_BIT   = 11;
  localparam int GRC_GLOBAL_BIT  = 15;
  localparam int GRC_RESTART_BIT = 14;
  localparam int SPC_INT_OE_BIT  = 0;
  localparam int SPC_INT_EN_BIT  = 1;
  localparam int SPC_INT_POL_BIT = 2;
  localparam int SPC_PS_EN_BIT   = 14;
  localparam int SPC_PS_SEL_LSB  = 12;
  localparam int SC3_FAST_LSB    = 0;
  localparam int IRQ_PEND_LSB    = 8;
  localparam logic [15:0] BMC_RST_VAL = 16'h0000;
  localparam logic [15:0] SC3_RST_VAL = 16'h0000;
  localparam logic [15:0] SPC_RST_VAL = 16'h0000;
  localparam logic [2:0]  IRQ_EN_RST  = 3'h0;
  // ----------------------------------------------------------------
  // host register map (word index)
  // ----------------------------------------------------------------
  localparam logic [1:0] HR_DATA = 2'h0;
  localparam logic [1:0] HR_CMD  = 2'h1;
  localparam logic [1:0] HR_CTRL = 2'h2;
  localparam logic [1:0] HR_STAT = 2'h3;
  localparam int CMD_WR_BIT      = 16;
  localparam int CTRL_PD_BIT     = 0;
  localparam int CTRL_HWRST_BIT  = 1;

  typedef enum logic [1:0] {
    PWR_ACTIVE  = 2'b00,
    PWR_DOWN    = 2'b01,
    PWR_ACT_WOL = 2'b10,
    PWR_PAS_WOL = 2'b11
  } prc_pwr_t;

  typedef enum logic [1:0] {
    RS_RUN    = 2'b00,
    RS_HOLD   = 2'b01,
    RS_SETTLE = 2'b11
  } prc_rst_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_XFER = 2'b01,
    HS_WAIT = 2'b11,
    HS_RST  = 2'b10
  } prc_host_t;

  // filtered pin level: moves once second and third stages agree
  function automatic logic prc_filt(input logic [2:0] s, input logic cur);
    return (s[1] == s[2]) ? s[2] : cur;
  endfunction : prc_filt

  function automatic logic prc_is_reset_cmd(input logic [4:0] a, input logic [15:0] d);
    return ((a == REG_BMC) && d[BMC_RESET_BIT]) ||
           ((a == REG_GRC) && (d[GRC_GLOBAL_BIT] || d[GRC_RESTART_BIT]));
  endfunction : prc_is_reset_cmd
endpackage : prc_pkg

// ---- verilog/prc_mgmt_if.sv ----
interface prc_mgmt_if;
  logic        req;
  logic        wr;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        ack;
  logic        rst_pin_n;
  logic        pd_h_o;
  logic        pd_h_oe;
  logic        pd_d_o;
  logic        pd_d_oe;
  logic        pd_pin;

  // shared pin with weak pull-up
  assign pd_pin = pd_d_oe ? pd_d_o : (pd_h_oe ? pd_h_o : 1'b1);

  modport phy (input req, wr, addr, wdata, rst_pin_n, pd_pin,
               output rdata, ack, pd_d_o, pd_d_oe);
  modport host (input rdata, ack, pd_pin,
                output req, wr, addr, wdata, rst_pin_n, pd_h_o, pd_h_oe);
endinterface : prc_mgmt_if

// ---- verilog/prc_win_count.sv ----
module prc_win_count #(
  parameter int THRESH = 20
) (
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic clr,
  input  wire logic ev,
  output logic      hit
);
  localparam int CW = $clog2(THRESH + 1);

  if (THRESH < 1) begin : g_chk
    $error("prc_win_count: THRESH must be at least 1");
  end

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  always_comb begin
    if (clr) begin
      cnt_d = ev ? CW'(1) : '0;
    end else if (ev && (cnt_q != CW'(THRESH))) begin
      cnt_d = cnt_q + CW'(1);
    end else begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign hit = (cnt_q == CW'(THRESH));
endmodule : prc_win_count

// ---- verilog/prc_phy_ctrl.sv ----
// The Avalon-MM slave port was decided locally.
module prc_phy_ctrl #(
  parameter int DEF_WIN = prc_pkg::DEF_WIN_CYC,
  parameter int SETTLE  = prc_pkg::SETTLE_CYC
) (
  input  wire logic       CLK,
  input  wire logic       RST_N,
  prc_mgmt_if.phy         MG,
  input  wire logic       LINK_GOOD,
  input  wire logic       RX_ERR,
  input  wire logic       MLT3_ERR,
  input  wire logic       SQ_LOW,
  input  wire logic       ENERGY_LOSS,
  input  wire logic [2:0] STRAP,
  output logic            LINK_UP,
  output logic            LINK_DROP,
  output logic            CIRC_RST,
  output prc_pkg::prc_pwr_t PWR_MODE,
  output logic [2:0]      STRAP_Q
);
  import prc_pkg::*;

  localparam int WCW = $clog2(DEF_WIN);
  localparam int SCW = $clog2(SETTLE);
  localparam int LCW = $clog2(HW_PULSE_CYC + 1);

  if (DEF_WIN <= FAST_WIN_CYC || SETTLE < 1) begin : g_chk
    $error("prc_phy_ctrl: DEF_WIN must exceed the fast window, SETTLE >= 1");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [2:0]     rs_q, rs_d, ps_q, ps_d, strap_q, strap_d;
  logic           rlv_q, rlv_d, plv_q, plv_d;
  logic [LCW-1:0] lo_q, lo_d;
  prc_rst_t       st_q, st_d;
  logic [SCW-1:0] sc_q, sc_d;
  logic [15:0]    bmc_q, bmc_d, sc3_q, sc3_d, spc_q, spc_d, rd_q, rd_d;
  logic [2:0]     en1_q, en1_d, pd1_q, pd1_d, en2_q, en2_d, pd2_q, pd2_d;
  logic [1:0]     grc_q, grc_d;
  logic [WCW-1:0] wc_q, wc_d;
  logic           elall_q, elall_d, link_q, link_d, blk_q, blk_d;
  logic           el_q, el_d, drop_q, drop_d, ack_q, ack_d;
  logic [2:0]     hq_q, hq_d;
  logic           io_q, io_d, ioe_q, ioe_d, crst_q, crst_d;
  prc_pwr_t       pm_q, pm_d;

  logic           wr_go, rd_go, hw_trig, done, mon, win_end, fast, drop;
  logic           hit_rx, hit_ml, hit_sq;
  logic [15:0]    rmux;

  // ----------------------------------------------------------------
  // fast-criterion event counters
  // ----------------------------------------------------------------
  prc_win_count #(.THRESH(RX_ERR_THRESH)) u_rx (
    .CLK(CLK), .RST_N(RST_N), .clr(~mon | win_end), .ev(RX_ERR), .hit(hit_rx)
  );
  prc_win_count #(.THRESH(MLT3_THRESH)) u_ml (
    .CLK(CLK), .RST_N(RST_N), .clr(~mon | win_end), .ev(MLT3_ERR), .hit(hit_ml)
  );
  prc_win_count #(.THRESH(SQ_THRESH)) u_sq (
    .CLK(CLK), .RST_N(RST_N), .clr(~mon | win_end), .ev(SQ_LOW), .hit(hit_sq)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    wr_go = MG.req && !ack_q && MG.wr;
    rd_go = MG.req && !ack_q && !MG.wr;
    ack_d = MG.req && !ack_q;
    rs_d  = {rs_q[1:0], MG.rst_pin_n};
    ps_d  = {ps_q[1:0], MG.pd_pin};
    rlv_d = prc_filt(rs_q, rlv_q);
    plv_d = prc_filt(ps_q, plv_q);
    lo_d  = rlv_q ? '0 : ((lo_q == LCW'(HW_PULSE_CYC)) ? lo_q : lo_q + LCW'(1));
    hw_trig = (lo_q == LCW'(HW_PULSE_CYC));
    // reset sequencer
    st_d = st_q;
    sc_d = sc_q;
    strap_d = strap_q;
    done = 1'b0;
    case (st_q)
      RS_RUN: begin
        if (hw_trig) begin
          st_d = RS_HOLD;
        end else if (wr_go && prc_is_reset_cmd(MG.addr, MG.wdata)) begin
          st_d = RS_SETTLE;
          sc_d = SCW'(SETTLE - 1);
        end
      end
      RS_HOLD: begin
        if (rlv_q) begin
          st_d = RS_SETTLE;
          sc_d = SCW'(SETTLE - 1);
          strap_d = STRAP;
        end
      end
      RS_SETTLE: begin
        if (hw_trig) begin
          st_d = RS_HOLD;
        end else if (sc_q == '0) begin
          st_d = RS_RUN;
          done = 1'b1;
        end else begin
          sc_d = sc_q - SCW'(1);
        end
      end
      default: st_d = RS_HOLD;
    endcase
    crst_d = (st_d != RS_RUN);

    // register file
    bmc_d = bmc_q;
    sc3_d = sc3_q;
    spc_d = spc_q;
    en1_d = en1_q;
    en2_d = en2_q;
    grc_d = grc_q;
    pd1_d = pd1_q;
    pd2_d = pd2_q;
    if (rd_go && MG.addr == REG_IRQ1) pd1_d = '0;
    if (rd_go && MG.addr == REG_IRQ2) pd2_d = '0;
    if (wr_go && st_q == RS_RUN) begin
      case (MG.addr)
        REG_BMC:  bmc_d = MG.wdata;
        REG_SC3:  sc3_d = MG.wdata;
        REG_SPC:  spc_d = MG.wdata;
        REG_IRQ1: en1_d = MG.wdata[2:0];
        REG_IRQ2: en2_d = MG.wdata[2:0];
        REG_GRC:  grc_d = MG.wdata[GRC_GLOBAL_BIT:GRC_RESTART_BIT];
        default:  ;
      endcase
      if (MG.addr == REG_BMC && MG.wdata[BMC_RESET_BIT]) begin
        bmc_d = BMC_RST_VAL;
        bmc_d[BMC_RESET_BIT] = 1'b1;
      end
    end
    if ((wr_go && st_q == RS_RUN && MG.addr == REG_GRC && MG.wdata[GRC_GLOBAL_BIT])
        || st_q == RS_HOLD) begin
      bmc_d = BMC_RST_VAL;
      sc3_d = SC3_RST_VAL;
      spc_d = SPC_RST_VAL;
      en1_d = IRQ_EN_RST;
      en2_d = IRQ_EN_RST;
      pd1_d = '0;
      pd2_d = '0;
      grc_d = {st_q != RS_HOLD, 1'b0};
    end
    if (done) begin
      bmc_d[BMC_RESET_BIT] = 1'b0;
      grc_d = '0;
    end

    // power modes
    if (bmc_q[BMC_PDOWN_BIT] || (!spc_q[SPC_INT_OE_BIT] && !plv_q)) begin
      pm_d = PWR_DOWN;
    end else if (spc_q[SPC_PS_EN_BIT]) begin
      pm_d = prc_pwr_t'(spc_q[SPC_PS_SEL_LSB +: 2]);
    end else begin
      pm_d = PWR_ACTIVE;
    end

    // link-loss monitor
    mon = (st_q == RS_RUN) && (pm_q == PWR_ACTIVE) && link_q;
    fast = |sc3_q[SC3_FAST_LSB +: 4];
    win_end = mon && (wc_q == '0);
    if (!mon || wc_q == '0) begin
      wc_d = fast ? WCW'(FAST_WIN_CYC - 1) : WCW'(DEF_WIN - 1);
    end else begin
      wc_d = wc_q - WCW'(1);
    end
    elall_d = (!mon || win_end) ? 1'b1 : (elall_q && ENERGY_LOSS);
    if (fast) begin
      drop = (sc3_q[SC3_FAST_LSB]     && hit_rx) ||
             (sc3_q[SC3_FAST_LSB + 1] && hit_ml) ||
             (sc3_q[SC3_FAST_LSB + 2] && hit_sq) ||
             (sc3_q[SC3_FAST_LSB + 3] && ENERGY_LOSS);
    end else begin
      drop = win_end && elall_q && ENERGY_LOSS;
    end
    drop = drop && mon;
    drop_d = drop;
    blk_d = drop ? 1'b1 : (LINK_GOOD ? blk_q : 1'b0);
    link_d = (st_q == RS_RUN) && (pm_q == PWR_ACTIVE) && !drop && LINK_GOOD &&
             (link_q || !blk_q);
    el_d = ENERGY_LOSS;
    hq_d = {hit_sq, hit_ml, hit_rx};

    // interrupt pending, set wins over read clear
    if (st_q != RS_HOLD) begin
      pd1_d = pd1_d | (en1_q & {done, ENERGY_LOSS && !el_q, drop});
      pd2_d = pd2_d | (en2_q & {hit_sq, hit_ml, hit_rx} & ~hq_q);
    end
    ioe_d = spc_q[SPC_INT_OE_BIT];
    io_d = (spc_q[SPC_INT_EN_BIT] && (|{pd1_q, pd2_q})) ~^ spc_q[SPC_INT_POL_BIT];

    // read mux
    case (MG.addr)
      REG_BMC:  rmux = bmc_q;
      REG_SC3:  rmux = sc3_q;
      REG_SPC:  rmux = spc_q;
      REG_IRQ1: rmux = {5'h00, pd1_q, 5'h00, en1_q};
      REG_IRQ2: rmux = {5'h00, pd2_q, 5'h00, en2_q};
      REG_GRC:  rmux = {grc_q, 14'h0000};
      default:  rmux = 16'h0000;
    endcase
    rd_d = rd_go ? rmux : rd_q;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rs_q <= 3'h7;
      ps_q <= 3'h7;
      rlv_q <= 1'b1;
      plv_q <= 1'b1;
      lo_q <= '0;
      st_q <= RS_HOLD;
      sc_q <= '0;
      strap_q <= 3'h0;
      bmc_q <= BMC_RST_VAL;
      sc3_q <= SC3_RST_VAL;
      spc_q <= SPC_RST_VAL;
      en1_q <= IRQ_EN_RST;
      en2_q <= IRQ_EN_RST;
      pd1_q <= 3'h0;
      pd2_q <= 3'h0;
      grc_q <= 2'h0;
      rd_q <= 16'h0000;
      ack_q <= 1'b0;
      wc_q <= '0;
      elall_q <= 1'b1;
      link_q <= 1'b0;
      blk_q <= 1'b0;
      el_q <= 1'b0;
      drop_q <= 1'b0;
      hq_q <= 3'h0;
      io_q <= 1'b1;
      ioe_q <= 1'b0;
      crst_q <= 1'b1;
      pm_q <= PWR_ACTIVE;
    end else begin
      rs_q <= rs_d;
      ps_q <= ps_d;
      rlv_q <= rlv_d;
      plv_q <= plv_d;
      lo_q <= lo_d;
      st_q <= st_d;
      sc_q <= sc_d;
      strap_q <= strap_d;
      bmc_q <= bmc_d;
      sc3_q <= sc3_d;
      spc_q <= spc_d;
      en1_q <= en1_d;
      en2_q <= en2_d;
      pd1_q <= pd1_d;
      pd2_q <= pd2_d;
      grc_q <= grc_d;
      rd_q <= rd_d;
      ack_q <= ack_d;
      wc_q <= wc_d;
      elall_q <= elall_d;
      link_q <= link_d;
      blk_q <= blk_d;
      el_q <= el_d;
      drop_q <= drop_d;
      hq_q <= hq_d;
      io_q <= io_d;
      ioe_q <= ioe_d;
      crst_q <= crst_d;
      pm_q <= pm_d;
    end
  end

  assign MG.rdata   = rd_q;
  assign MG.ack     = ack_q;
  assign MG.pd_d_o  = io_q;
  assign MG.pd_d_oe = ioe_q;
  assign LINK_UP    = link_q;
  assign LINK_DROP  = drop_q;
  assign CIRC_RST   = crst_q;
  assign PWR_MODE   = pm_q;
  assign STRAP_Q    = strap_q;
endmodule : prc_phy_ctrl

// ---- verilog/prc_mgmt_host.sv ----
module prc_mgmt_host #(
  parameter int POR_HOLD = prc_pkg::POR_HOLD_CYC,
  parameter int SETTLE   = prc_pkg::SETTLE_CYC,
  parameter int SW_WAIT  = prc_pkg::SW_WAIT_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  prc_mgmt_if.host         MG,
  input  wire logic [1:0]  AV_ADDRESS,
  input  wire logic        AV_READ,
  input  wire logic        AV_WRITE,
  input  wire logic [31:0] AV_WRITEDATA,
  output logic [31:0]      AV_READDATA,
  output logic             AV_WAITREQUEST
);
  import prc_pkg::*;

  localparam int CW = $clog2(SW_WAIT + 1);

  if (POR_HOLD < 1 || SETTLE < 1 || SW_WAIT < 1 || POR_HOLD > SW_WAIT ||
      SETTLE > SW_WAIT || HW_PULSE_CYC > SW_WAIT) begin : g_chk
    $error("prc_mgmt_host: counts must be >= 1 and fit the counter");
  end

  prc_host_t   hs_q, hs_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic        req_q, req_d, wr_q, wr_d, rpin_q, rpin_d, pdo_q, pdo_d;
  logic        wq_q, wq_d, plv_q, plv_d;
  logic [4:0]  addr_q, addr_d;
  logic [15:0] wdat_q, wdat_d, rdat_q, rdat_d;
  logic [2:0]  syn_q, syn_d;
  logic [31:0] avrd_q, avrd_d;
  logic        take;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    take = (AV_READ || AV_WRITE) && !wq_q;
    wq_d = !((AV_READ || AV_WRITE) && wq_q);
    syn_d = {syn_q[1:0], MG.pd_pin};
    plv_d = prc_filt(syn_q, plv_q);
    hs_d = hs_q;
    cnt_d = cnt_q;
    req_d = req_q;
    wr_d = wr_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    rdat_d = rdat_q;
    rpin_d = rpin_q;
    pdo_d = pdo_q;
    if (take && AV_WRITE && AV_ADDRESS == HR_CTRL) pdo_d = AV_WRITEDATA[CTRL_PD_BIT];
    case (hs_q)
      HS_IDLE: begin
        if (take && AV_WRITE && AV_ADDRESS == HR_DATA) wdat_d = AV_WRITEDATA[15:0];
        if (take && AV_WRITE && AV_ADDRESS == HR_CMD) begin
          hs_d = HS_XFER;
          req_d = 1'b1;
          wr_d = AV_WRITEDATA[CMD_WR_BIT];
          addr_d = AV_WRITEDATA[4:0];
        end else if (take && AV_WRITE && AV_ADDRESS == HR_CTRL &&
                     AV_WRITEDATA[CTRL_HWRST_BIT]) begin
          hs_d = HS_RST;
          cnt_d = CW'(HW_PULSE_CYC - 1);
          rpin_d = 1'b0;
        end
      end
      HS_XFER: begin
        if (MG.ack) begin
          req_d = 1'b0;
          rdat_d = wr_q ? rdat_q : MG.rdata;
          if (wr_q && prc_is_reset_cmd(addr_q, wdat_q)) begin
            hs_d = HS_WAIT;
            cnt_d = CW'(SW_WAIT - 1);
          end else begin
            hs_d = HS_IDLE;
          end
        end
      end
      HS_RST: begin
        if (cnt_q == '0) begin
          rpin_d = 1'b1;
          hs_d = HS_WAIT;
          cnt_d = CW'(SETTLE - 1);
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
      HS_WAIT: begin
        if (cnt_q == '0) begin
          hs_d = HS_IDLE;
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
      default: hs_d = HS_IDLE;
    endcase
    avrd_d = avrd_q;
    if ((AV_READ || AV_WRITE) && wq_q) begin
      case (AV_ADDRESS)
        HR_DATA: avrd_d = {16'h0000, rdat_q};
        HR_CMD:  avrd_d = {15'h0000, wr_q, 11'h000, addr_q};
        HR_CTRL: avrd_d = {31'h00000000, pdo_q};
        default: avrd_d = {29'h00000000, !rpin_q, !plv_q, hs_q != HS_IDLE};
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      hs_q <= HS_RST;
      cnt_q <= CW'(POR_HOLD - 1);
      req_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 5'h00;
      wdat_q <= 16'h0000;
      rdat_q <= 16'h0000;
      rpin_q <= 1'b0;
      pdo_q <= 1'b0;
      wq_q <= 1'b1;
      syn_q <= 3'h7;
      plv_q <= 1'b1;
      avrd_q <= 32'h00000000;
    end else begin
      hs_q <= hs_d;
      cnt_q <= cnt_d;
      req_q <= req_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      rdat_q <= rdat_d;
      rpin_q <= rpin_d;
      pdo_q <= pdo_d;
      wq_q <= wq_d;
      syn_q <= syn_d;
      plv_q <= plv_d;
      avrd_q <= avrd_d;
    end
  end

  assign MG.req         = req_q;
  assign MG.wr          = wr_q;
  assign MG.addr        = addr_q;
  assign MG.wdata       = wdat_q;
  assign MG.rst_pin_n   = rpin_q;
  assign MG.pd_h_o      = 1'b0;
  assign MG.pd_h_oe     = pdo_q;
  assign AV_READDATA    = avrd_q;
  assign AV_WAITREQUEST = wq_q;
endmodule : prc_mgmt_host

// ---- sim/prc_mgmt_asserts.sv ----
module prc_mgmt_asserts #(
  parameter int SW_WAIT = 200
) (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        req,
  input wire logic        wr,
  input wire logic [4:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        ack,
  input wire logic        rst_pin_n,
  input wire logic        pd_h_o,
  input wire logic        pd_h_oe,
  input wire logic        pd_d_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // pulse length and quiet time counters
  // ------------------------------------------------------------
  logic [7:0] low_q, low_d;
  logic [8:0] gap_q, gap_d;
  logic       hi_q, hi_d;
  wire rcmd = ack && wr && (addr == 5'h1f ? wdata[15:14] != 2'h0 : addr == 5'h00 && wdata[15]);
  always_comb begin
    low_d = rst_pin_n ? 8'h00 : low_q + 8'(low_q != 8'hff);
    hi_d  = hi_q | rst_pin_n;
    gap_d = rcmd ? 9'h000 : gap_q + 9'(gap_q != 9'h1ff);
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      low_q <= 8'h00;
      hi_q  <= 1'b0;
      gap_q <= 9'h1ff;
    end else begin
      low_q <= low_d;
      hi_q  <= hi_d;
      gap_q <= gap_d;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  chk_ack_single: assert property (ack |=> !ack)
    else $error("ack held longer than one cycle");
  chk_ack_cause: assert property (ack |-> $past(req))
    else $error("ack without request");
  chk_req_held: assert property (req && !ack |=> req && $stable({wr, addr, wdata}))
    else $error("request changed before ack");
  chk_req_served: assert property ($rose(req) |-> ##[1:4] ack)
    else $error("request not answered");
  chk_host_low: assert property (pd_h_oe |-> !pd_h_o)
    else $error("host drives shared pin high");
  chk_pin_input: assert property (!$past(RST_N) |-> !pd_d_oe)
    else $error("shared pin driven after reset");
  chk_pulse_len: assert property ($rose(rst_pin_n) && hi_q |-> low_q >= 8'd100)
    else $error("reset pulse too short");
  chk_sw_quiet: assert property ($rose(req) |-> gap_q >= SW_WAIT - 4)
    else $error("access too soon after soft reset");
  chk_rdata_hold: assert property ($changed(rdata) |-> ack && !wr)
    else $error("read data changed outside a read");
endmodule : prc_mgmt_asserts

// ---- sim/tb_phy_reset_power_linkdown_ctrl.sv ----
module tb_phy_reset_power_linkdown_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import prc_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, av_rd = 1'b0, av_wr = 1'b0, av_wait;
  logic [1:0]  av_addr = 2'h0;
  logic [31:0] av_wdata = 32'h0, av_rdata, bus_q;
  logic        lgood = 1'b1, eloss = 1'b0, link_up, link_drop, circ_rst, seen_rst;
  logic [2:0]  ev = 3'h0, strap = 3'h2, strap_q;
  prc_pwr_t    pwr;
  int          drops = 0, d0 = 0, fail_count = 0, checks_done = 0;
  int          thr [3] = '{32, 20, 20};
  logic [4:0]  regs [6] = '{REG_BMC, REG_SC3, REG_SPC, REG_IRQ1, REG_IRQ2, 5'h05};
  always #5 clk = ~clk;
  always @(posedge clk) if (link_drop === 1'b1) drops <= drops + 1;
  always @(posedge clk) if (circ_rst === 1'b1) seen_rst <= 1'b1;
  prc_mgmt_if mg ();
  prc_phy_ctrl #(.DEF_WIN(2000), .SETTLE(50)) i_prc_phy_ctrl (
    .CLK(clk), .RST_N(rst_n), .MG(mg), .LINK_GOOD(lgood), .RX_ERR(ev[0]),
    .MLT3_ERR(ev[1]), .SQ_LOW(ev[2]), .ENERGY_LOSS(eloss), .STRAP(strap),
    .LINK_UP(link_up), .LINK_DROP(link_drop), .CIRC_RST(circ_rst),
    .PWR_MODE(pwr), .STRAP_Q(strap_q));
  prc_mgmt_host #(.POR_HOLD(50), .SETTLE(50), .SW_WAIT(200)) i_prc_mgmt_host (
    .CLK(clk), .RST_N(rst_n), .MG(mg), .AV_ADDRESS(av_addr), .AV_READ(av_rd),
    .AV_WRITE(av_wr), .AV_WRITEDATA(av_wdata), .AV_READDATA(av_rdata),
    .AV_WAITREQUEST(av_wait));
  prc_mgmt_asserts u_chk (
    .CLK(clk), .RST_N(rst_n), .req(mg.req), .wr(mg.wr), .addr(mg.addr),
    .wdata(mg.wdata), .rdata(mg.rdata), .ack(mg.ack), .rst_pin_n(mg.rst_pin_n),
    .pd_h_o(mg.pd_h_o), .pd_h_oe(mg.pd_h_oe), .pd_d_oe(mg.pd_d_oe));
  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic close_out();
    if (fail_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic bound(input bit ok);
    if (!ok) begin
      fail_count++;
      close_out();
    end
  endtask : bound
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    av_rd <= !w;
    av_wr <= w;
    av_addr <= a;
    av_wdata <= d;
    n = 0;
    // look between edges so the rising edge that takes the request is not raced
    do begin
      @(negedge clk);
      n++;
    end while (av_wait !== 1'b0 && n < 50);
    @(posedge clk);
    bus_q = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    bound(av_wait === 1'b0);
  endtask : bus
  task automatic idle();
    int n;
    for (n = 0; n < 900; n++) begin
      bus(1'b0, HR_STAT, 32'h0);
      if ((bus_q & 32'h5) === 32'h0) break;
    end
    bound(n < 900);
  endtask : idle
  task automatic dwr(input logic [4:0] r, input logic [15:0] v);
    idle();
    bus(1'b1, HR_DATA, {16'h0, v});
    bus(1'b1, HR_CMD, {15'h0, 1'b1, 11'h0, r});
    idle();
  endtask : dwr
  task automatic drd(input logic [4:0] r, input logic [15:0] v);
    idle();
    bus(1'b1, HR_CMD, {27'h0, r});
    idle();
    bus(1'b0, HR_DATA, 32'h0);
    chk({16'h0, bus_q[15:0]}, {16'h0, v});
  endtask : drd
  task automatic burst(input int i, input int n);
    ev <= 3'h1 << i;
    repeat (n) @(posedge clk);
    ev <= 3'h0;
    @(posedge clk);
  endtask : burst
  task automatic relink();
    int n;
    lgood <= 1'b0;
    repeat (4) @(posedge clk);
    lgood <= 1'b1;
    for (n = 0; n < 100 && link_up !== 1'b1; n++) @(posedge clk);
    bound(link_up === 1'b1);
    d0 = drops;
  endtask : relink
  task automatic wdrop(input int lim);
    int n;
    for (n = 0; n < lim && drops == d0; n++) @(posedge clk);
    chk(drops - d0, 1);
  endtask : wdrop
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    int i;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    idle();
    chk(32'(strap_q), 2);
    foreach (regs[k]) drd(regs[k], 16'h0);
    bus(1'b1, HR_CTRL, 32'h1);
    repeat (10) @(posedge clk);
    chk(32'(pwr), PWR_DOWN);
    drd(REG_SC3, 16'h0);
    bus(1'b1, HR_CTRL, 32'h0);
    dwr(REG_BMC, 16'h0800);
    chk(32'(pwr), PWR_DOWN);
    dwr(REG_BMC, 16'h0);
    for (i = 1; i < 4; i++) begin
      dwr(REG_SPC, 16'h4000 | 16'(i << 12));
      chk(32'(pwr), i);
    end
    dwr(REG_SPC, 16'h0);
    chk(32'(pwr), PWR_ACTIVE);
    dwr(REG_SPC, 16'h0003);
    dwr(REG_IRQ1, 16'h0001);
    for (i = 0; i < 4; i++) begin
      dwr(REG_SC3, 16'(1 << i));
      relink();
      if (i < 3) begin
        burst(i, thr[i] - 1);
        repeat (1100) @(posedge clk);
        burst(i, thr[i] - 1);
        burst((i + 1) % 3, 64);
        repeat (1100) @(posedge clk);
        chk(drops - d0, 0);
        burst(i, 2 * thr[i]);
      end else begin
        eloss <= 1'b1;
      end
      wdrop(1000);
      eloss <= 1'b0;
      chk(32'(link_up), 0);
      if (i == 0) begin
        chk(32'(mg.pd_pin), 0);
        drd(REG_IRQ1, 16'h0101);
        drd(REG_IRQ1, 16'h0001);
        chk(32'(mg.pd_pin), 1);
      end
    end
    dwr(REG_SPC, 16'h0);
    dwr(REG_SC3, 16'h0);
    relink();
    eloss <= 1'b1;
    wdrop(4100);
    eloss <= 1'b0;
    dwr(REG_SC3, 16'h0005);
    dwr(REG_BMC, 16'h8800);
    drd(REG_BMC, 16'h0);
    drd(REG_SC3, 16'h0005);
    seen_rst = 1'b0;
    dwr(REG_GRC, 16'h4000);
    chk(32'(seen_rst), 1);
    drd(REG_SC3, 16'h0005);
    dwr(REG_SPC, 16'h0004);
    dwr(REG_GRC, 16'h8000);
    drd(REG_SC3, 16'h0);
    drd(REG_SPC, 16'h0);
    chk(32'(strap_q), 2);
    strap <= 3'h5;
    dwr(REG_SC3, 16'h0005);
    bus(1'b1, HR_CTRL, 32'h2);
    idle();
    drd(REG_SC3, 16'h0);
    chk(32'(strap_q), 5);
    close_out();
  end
endmodule : tb_phy_reset_power_linkdown_ctrl
